/* mlc_consts.svh */
`ifndef MLC_CONSTS_SVH
`define MLC_CONSTS_SVH
`define MLC_WORD_W     16
`define MLC_BYTE_W     8
`define MLC_CHAR_W     6
`define MLC_ODD_PARITY 1'b1
`endif

/* mlc_pkg.sv */
package mlc_pkg;
	typedef logic [15:0] mlc_word_t;
	typedef enum logic [5:0]
	{
		ST_IDLE    = 6'b00_0001,
		ST_WR_ACK  = 6'b00_0010,
		ST_WR_HOST = 6'b00_0100,
		ST_RD_HOST = 6'b00_1000,
		ST_RD_DEM  = 6'b01_0000,
		ST_DONE    = 6'b10_0000
	} mlc_state_t;
endpackage : mlc_pkg

/* mlc_par_if.sv */
`timescale 1ns/10ps
interface mlc_par_if;
	logic [15:0] word;
	logic        oddSense;
	logic        parity;
	modport gen (input word, input oddSense, output parity);
	modport use_ (output word, output oddSense, input parity);
endinterface : mlc_par_if

/* mlc_parity_gen.sv */
`timescale 1ns/10ps
module mlc_parity_gen
(
	mlc_par_if.gen p
);
	// odd sense: the parity bit makes the total count of ones odd
	assign p.parity = (^p.word) ^ p.oddSense;
endmodule : mlc_parity_gen

/* mlc_sync2.sv */
`timescale 1ns/10ps
module mlc_sync2
#(
	parameter int W = 1
)
(
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;
	// first stage feeds only the second
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			meta_reg <= '0;
			q        <= '0;
		end
		else
		begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule : mlc_sync2

/* mainframe_link_controller.sv */
`timescale 1ns/10ps
`include "mlc_consts.svh"
// How it works
// R01 - whole 16-bit words move in parallel, each under a demand-response handshake
// R02 - host start or adapter select may both begin a block transfer
// R03 - outbound word is presented as high byte then low byte fields
// R04 - inbound word gives two 6-bit characters; top four bits dropped
// R05 - host side talks to the data-break word port
// R06 - adapter write-ready latches the data bus into the buffer
// R07 - parity of the latched word is checked against adapter parity
// R08 - parity of a host-loaded buffer is computed from buffer contents
// R09 - data and computed parity go to the adapter together
// R10 - adapter drives its parity with the data bus
// R11 - write-select means write; interrupts host if write enable set
// R12 - read-select means read; interrupts host if read enable set
// R13 - adapter data is settled before write-ready rises
// R14 - adapter read-ready shows it can take a word
// R15 - demand acknowledges a word taken during an adapter write
// R16 - during read, demand means data valid; data held while demand high
// R17 - parity mismatch on a write word raises the parity fault line
// R18 - end of transfer raises done line; no more words moved after
// R19 - adapter reports device and channel end on the done line
// R20 - an interrupt line asks the adapter to interrupt the mainframe
// R21 - adapter reports its own parity error on a read word
// R22 - demand drops only after adapter ready falls, four-phase
// R23 - odd parity over the 16 data bits unless configured otherwise
module mainframe_link_controller
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// host control
	input  wire logic        writeEnable,
	input  wire logic        readEnable,
	input  wire logic        evenParity,
	input  wire logic        hostStart,
	input  wire logic        hostEndRecord,
	input  wire logic        hostMfIntReq,
	// host interrupt and status
	output logic             hostInterrupt,
	output logic             hostWrIntFlag,
	output logic             hostRdIntFlag,
	output logic             hostParityErr,
	// data break port
	output logic             brkReqIn,
	input  wire logic        brkAckIn,
	output logic      [15:0] brkDataIn,
	output logic      [5:0]  brkCharHi,
	output logic      [5:0]  brkCharLo,
	// break port, host word toward the adapter
	output logic             brkReqOut,
	input  wire logic        brkAckOut,
	input  wire logic [15:0] brkDataOut,
	// parallel_channel_adapter pins
	input  wire logic [15:0] pcaBusOut,
	input  wire logic        pcaParityOut,
	input  wire logic        pcaWriteSelect,
	input  wire logic        pcaReadSelect,
	input  wire logic        pcaWriteReady,
	input  wire logic        pcaReadReady,
	input  wire logic        pcaParityError,
	// parallel_channel_adapter lines driven by this controller
	output logic      [15:0] pcaBusIn,
	output logic             pcaParityIn,
	output logic      [7:0]  pcaByteHi,
	output logic      [7:0]  pcaByteLo,
	output logic             pcaDemand,
	output logic             controller_parity_fault,
	output logic             transfer_done_line,
	output logic             pcaInterrupt
);
	mlc_pkg::mlc_state_t state_reg;
	mlc_pkg::mlc_state_t state_next;
	// synchronised adapter pins
	logic [15:0] sBus;
	logic        sPar;
	logic        sWs;
	logic        sRs;
	logic        sWr;
	logic        sRr;
	logic        sPe;
	// datapath and handshake registers
	logic [15:0] buf_reg;
	logic        bufPar_reg;
	logic        demand_reg;
	logic        fault_reg;
	logic        done_reg;
	logic        wrMode_reg;
	logic        rdMode_reg;
	// select edge history and host status
	logic        wsPrev_reg;
	logic        rsPrev_reg;
	logic        wrFlag_reg;
	logic        rdFlag_reg;
	logic        pErr_reg;
	logic        inReq_reg;
	logic        outReq_reg;
	logic        mfInt_reg;
	// decode wires
	logic        chkPar;
	logic        genPar;
	logic        wsRise;
	logic        rsRise;
	logic        mismatch;
	logic        oddSel;
	logic [15:0] bufNext;
	logic        loadWr;
	logic        loadRd;
	logic        clearIdle;
	logic        enterDone;
	logic        doneNext;
	logic        demandNext;
	logic        inReqNext;
	logic        outReqNext;

	// sticky bit: a new event wins over a clear in the same cycle
	function automatic logic stickyNext
	(
		input logic ev,
		input logic flag,
		input logic clr
	);
		return ev | (flag & ~clr);
	endfunction : stickyNext

	// adapter pins come from another clock's world
	mlc_sync2 #(.W(21)) uSync
	(
		.clk   (clk),
		.rst_n (rst_n),
		.d     ({pcaBusOut, pcaParityOut, pcaWriteSelect, pcaReadSelect,
			pcaWriteReady, pcaReadReady}),
		.q     ({sBus, sPar, sWs, sRs, sWr, sRr})
	);
	// the error pin gets a pair of its own, apart from the handshake word
	mlc_sync2 #(.W(1)) uSyncPe
	(
		.clk   (clk),
		.rst_n (rst_n),
		.d     (pcaParityError),
		.q     (sPe)
	);

	// one parity generator checks inbound bus, one covers the buffer
	mlc_par_if chkIf ();
	mlc_par_if genIf ();
	// parity sense is a host choice; odd is taken when nothing says otherwise
	assign oddSel        = evenParity ? 1'b0 : `MLC_ODD_PARITY; // R23
	assign chkIf.word    = sBus; // R07
	assign chkIf.oddSense = oddSel;
	assign genIf.word    = bufNext; // R08
	assign genIf.oddSense = oddSel;
	mlc_parity_gen uChk (.p(chkIf));
	mlc_parity_gen uGen (.p(genIf));
	assign chkPar = chkIf.parity;
	assign genPar = genIf.parity;

	// decode of select edges and parity compare
	assign wsRise   = sWs & ~wsPrev_reg; // R11
	assign rsRise   = sRs & ~rsPrev_reg; // R12
	assign mismatch = chkPar != sPar; // R07 R10

	// buffer source; parity is worked from the value being stored, so the
	// parity pin never lags the bus by a cycle when the buffer is reloaded
	assign loadWr  = state_reg == mlc_pkg::ST_IDLE && state_next == mlc_pkg::ST_WR_ACK; // R06
	assign loadRd  = state_reg == mlc_pkg::ST_RD_HOST && brkAckOut; // R05
	assign bufNext = loadWr ? sBus : (loadRd ? brkDataOut : buf_reg); // R06 R08

	// next values of status and handshake lines
	assign clearIdle  = state_reg == mlc_pkg::ST_IDLE && hostStart;
	assign enterDone  = state_next == mlc_pkg::ST_DONE && state_reg != mlc_pkg::ST_DONE; // R18
	assign doneNext   = stickyNext(enterDone, done_reg, hostStart); // R18
	assign demandNext = (state_next == mlc_pkg::ST_WR_ACK) ||
		(state_reg == mlc_pkg::ST_RD_DEM && state_next == mlc_pkg::ST_RD_DEM); // R15 R16
	assign inReqNext  = state_next == mlc_pkg::ST_WR_HOST && !brkAckIn; // R05
	assign outReqNext = state_next == mlc_pkg::ST_RD_HOST && !brkAckOut; // R05

	// next-state logic; adapter writes fill buffer then hand word to host,
	// reads fetch a host word then show it under demand
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			// a close request beats a waiting word
			mlc_pkg::ST_IDLE:
			begin
				if (hostEndRecord)
					state_next = mlc_pkg::ST_DONE; // R18
				else if (wrMode_reg && sWr)
					state_next = mlc_pkg::ST_WR_ACK; // R06 R13
				else if (rdMode_reg && sRr)
					state_next = mlc_pkg::ST_RD_HOST; // R14
			end
			// demand holds until the adapter lets go of write-ready
			mlc_pkg::ST_WR_ACK:
			begin
				if (!sWr)
					state_next = mlc_pkg::ST_WR_HOST; // R22
			end
			// word waits for the host; a slow host stalls the adapter
			mlc_pkg::ST_WR_HOST:
			begin
				if (brkAckIn)
					state_next = mlc_pkg::ST_IDLE; // R05
			end
			// fetch the next host word for the adapter
			mlc_pkg::ST_RD_HOST:
			begin
				if (brkAckOut)
					state_next = mlc_pkg::ST_RD_DEM; // R05
			end
			// word and parity stand until read-ready falls
			mlc_pkg::ST_RD_DEM:
			begin
				if (!sRr && demand_reg)
					state_next = mlc_pkg::ST_IDLE; // R22
			end
			// only the host may reopen the link
			mlc_pkg::ST_DONE:
			begin
				if (hostStart)
					state_next = mlc_pkg::ST_IDLE; // R02
			end
			default:
				state_next = mlc_pkg::ST_IDLE;
		endcase
	end

	// state, buffer and handshake lines
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_reg  <= mlc_pkg::ST_DONE;
			buf_reg    <= 16'h0000;
			bufPar_reg <= 1'b0;
			demand_reg <= 1'b0;
			fault_reg  <= 1'b0;
		end
		else
		begin
			state_reg  <= state_next;
			buf_reg    <= bufNext; // R05 R06
			bufPar_reg <= genPar; // R08 R09
			demand_reg <= demandNext; // R15 R16
			// a faulty word wins over a restart in the same cycle
			if (loadWr)
				fault_reg <= mismatch; // R17
			else if (clearIdle)
				fault_reg <= 1'b0;
		end
	end

	// transfer direction latched from select rising; done ends it
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wsPrev_reg <= 1'b0;
			rsPrev_reg <= 1'b0;
			wrMode_reg <= 1'b0;
			rdMode_reg <= 1'b0;
			done_reg   <= 1'b0;
		end
		else
		begin
			wsPrev_reg <= sWs;
			rsPrev_reg <= sRs;
			if (state_next == mlc_pkg::ST_DONE)
			begin
				wrMode_reg <= 1'b0; // R18
				rdMode_reg <= 1'b0;
			end
			else if (wsRise)
			begin
				wrMode_reg <= 1'b1; // R11 R02
				rdMode_reg <= 1'b0;
			end
			else if (rsRise)
			begin
				rdMode_reg <= 1'b1; // R12 R02
				wrMode_reg <= 1'b0;
			end
			// done stands until the host restarts; a new close wins over it
			done_reg   <= doneNext; // R18
		end
	end

	// sticky host flags: a new event wins over the same-cycle clear; the adapter interrupt just follows its request
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wrFlag_reg <= 1'b0;
			rdFlag_reg <= 1'b0;
			pErr_reg   <= 1'b0;
			mfInt_reg  <= 1'b0;
		end
		else
		begin
			wrFlag_reg <= stickyNext(wsRise && writeEnable, wrFlag_reg, hostStart); // R11
			rdFlag_reg <= stickyNext(rsRise && readEnable, rdFlag_reg, hostStart); // R12
			pErr_reg   <= stickyNext(sPe, pErr_reg, hostStart); // R21
			mfInt_reg  <= hostMfIntReq; // R20
		end
	end

	// break requests are registered so they can't glitch at the host
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			inReq_reg  <= 1'b0;
			outReq_reg <= 1'b0;
		end
		else
		begin
			inReq_reg  <= inReqNext; // R05
			outReq_reg <= outReqNext; // R05
		end
	end

	// output assignment; the bus changes only on a buffer load, never while demand holds
	// the host sees word bits 11:0 as two characters; bits 15:12 are dropped
	assign pcaBusIn                = buf_reg; // R09 R16
	assign pcaParityIn             = bufPar_reg; // R09
	assign pcaByteHi               = buf_reg[15:8]; // R03
	assign pcaByteLo               = buf_reg[7:0]; // R03
	assign pcaDemand               = demand_reg; // R01
	assign controller_parity_fault = fault_reg; // R17
	assign transfer_done_line      = done_reg; // R18 R19
	assign pcaInterrupt            = mfInt_reg; // R20
	assign brkDataIn               = buf_reg;
	assign brkCharHi               = buf_reg[11:6]; // R04
	assign brkCharLo               = buf_reg[5:0]; // R04
	assign brkReqIn                = inReq_reg;
	assign brkReqOut               = outReq_reg;
	assign hostWrIntFlag           = wrFlag_reg;
	assign hostRdIntFlag           = rdFlag_reg;
	assign hostParityErr           = pErr_reg;
	assign hostInterrupt           = wrFlag_reg | rdFlag_reg;
endmodule : mainframe_link_controller

/* mlc_checker.sv */
`timescale 1ns/10ps
module mlc_checker
(
	// clock, reset and host controls
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        writeEnable,
	input wire logic        evenParity,
	input wire logic        hostMfIntReq,
	input wire logic        hostWrIntFlag,
	// data break port
	input wire logic [15:0] brkDataIn,
	input wire logic [5:0]  brkCharHi,
	input wire logic [5:0]  brkCharLo,
	input wire logic        brkReqOut,
	// adapter pins
	input wire logic        pcaWriteSelect,
	input wire logic        pcaWriteReady,
	input wire logic        pcaReadReady,
	input wire logic [15:0] pcaBusIn,
	input wire logic        pcaParityIn,
	input wire logic [7:0]  pcaByteHi,
	input wire logic [7:0]  pcaByteLo,
	input wire logic        pcaDemand,
	input wire logic        controller_parity_fault,
	input wire logic        transfer_done_line,
	input wire logic        pcaInterrupt
);
	// pins pass two sync flops and one state edge, so causes are three edges back
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_byte_split: assert property ({pcaByteHi, pcaByteLo} == pcaBusIn)
		else $error("byte halves differ from bus");
	a_char_split: assert property ({brkCharHi, brkCharLo} == brkDataIn[11:0])
		else $error("characters differ from word");
	a_par_out: assert property (pcaDemand |-> pcaParityIn == (^pcaBusIn ^ !evenParity))
		else $error("parity wrong while demand high");
	a_data_held: assert property (pcaDemand && $past(pcaDemand) |-> $stable(pcaBusIn))
		else $error("data moved under demand");
	a_dem_rise: assert property ($rose(pcaDemand) |-> $past(pcaWriteReady || pcaReadReady, 3))
		else $error("demand rose without ready");
	a_dem_fall: assert property ($fell(pcaDemand) |-> $past(!pcaWriteReady && !pcaReadReady, 3))
		else $error("demand fell before ready dropped");
	a_fault_dem: assert property ($rose(controller_parity_fault) |-> pcaDemand)
		else $error("fault raised outside a taken word");
	a_done_quiet: assert property (transfer_done_line |-> !pcaDemand && !brkReqOut)
		else $error("transfer after done line");
	a_mf_int: assert property ($past(rst_n) |-> pcaInterrupt == $past(hostMfIntReq))
		else $error("adapter interrupt not following request");
	a_wr_int: assert property ($rose(hostWrIntFlag) |-> $past(writeEnable) && $past(pcaWriteSelect, 3))
		else $error("write flag without select and enable");
endmodule : mlc_checker
bind mainframe_link_controller mlc_checker u_chk (.*);

/* mlc_pca_model.sv */
`timescale 1ns/10ps
module mlc_pca_model
(
	// clock and parity sense
	input  wire logic        clk,
	input  wire logic        evenParity,
	// adapter side of the link
	output logic      [15:0] pcaBusOut,
	output logic             pcaParityOut,
	output logic             pcaWriteReady,
	output logic             pcaReadReady,
	output logic             pcaParityError,
	output logic             endStatus,
	input  wire logic [15:0] pcaBusIn,
	input  wire logic        pcaParityIn,
	input  wire logic        pcaDemand,
	input  wire logic        transfer_done_line
);
	initial
	begin
		pcaBusOut = 16'h0000;
		pcaParityOut = 0;
		pcaWriteReady = 0;
		pcaReadReady = 0;
		pcaParityError = 0;
	end
	// device and channel end status follow the done line
	always @(posedge clk) endStatus <= transfer_done_line;
	// bounded wait so a refusing controller cannot hang the model
	task automatic waitDem(input logic lvl, output logic ok);
		int i;
		ok = 0;
		for (i = 0; i < 30 && !ok; i++)
		begin
			@(negedge clk);
			ok = (pcaDemand === lvl);
		end
	endtask : waitDem
	// one word toward the controller; bad flips parity on purpose
	task automatic wr(input logic [15:0] d, input logic bad, input int slow, output logic ok);
		logic k;
		pcaBusOut = d;
		pcaParityOut = ^d ^ !evenParity ^ bad;
		@(negedge clk);
		pcaWriteReady = 1;
		waitDem(1, ok);
		repeat (slow) @(negedge clk);
		pcaWriteReady = 0;
		waitDem(0, k);
		pcaBusOut = ~d;
	endtask : wr
	// one word from the controller, parity checked here; bad inverts the reported error
	task automatic rd(input int slow, input logic bad, output logic [15:0] d, output logic ok);
		logic k;
		pcaReadReady = 1;
		waitDem(1, ok);
		d = pcaBusIn;
		pcaParityError = (pcaParityIn !== (^pcaBusIn ^ !evenParity)) ^ bad;
		repeat (slow) @(negedge clk);
		pcaReadReady = 0;
		waitDem(0, k);
	endtask : rd
endmodule : mlc_pca_model

/* tb.sv */
`timescale 1ns/10ps
module tb;
	logic        clk, rst_n, writeEnable, readEnable, evenParity, hostStart;
	logic        hostEndRecord, hostMfIntReq, hostInterrupt, hostWrIntFlag;
	logic        hostRdIntFlag, hostParityErr, brkReqIn, brkAckIn, brkReqOut, brkAckOut;
	logic [15:0] brkDataIn, brkDataOut, pcaBusOut, pcaBusIn, d;
	logic [5:0]  brkCharHi, brkCharLo;
	logic [7:0]  pcaByteHi, pcaByteLo;
	logic        pcaParityOut, pcaWriteSelect, pcaReadSelect, pcaWriteReady, pcaReadReady;
	logic        pcaParityError, pcaParityIn, pcaDemand, controller_parity_fault;
	logic        transfer_done_line, pcaInterrupt, endStatus, ok;
	int          errors = 0;
	int          n_compared = 0;
	mainframe_link_controller u_dut (.*);
	mlc_pca_model u_pca (.*);
	initial
	begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic end_sim();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_sim
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick
	task automatic restart();
		hostStart = 1;
		tick(1);
		hostStart = 0;
	endtask : restart
	// host takes the word offered on the break port
	task automatic takeHost(input logic [15:0] e);
		int i;
		for (i = 0; i < 20 && brkReqIn !== 1'b1; i++)
			tick(1);
		chk("brkDataIn", e, brkDataIn);
		chk("brkCharHi", {10'h000, e[11:6]}, {10'h000, brkCharHi});
		brkAckIn = 1;
		tick(1);
		brkAckIn = 0;
	endtask : takeHost
	task automatic giveHost(input logic [15:0] v);
		int i;
		for (i = 0; i < 20 && brkReqOut !== 1'b1; i++)
			tick(1);
		brkDataOut = v;
		brkAckOut = 1;
		tick(1);
		brkAckOut = 0;
	endtask : giveHost
	task automatic sc_write();
		writeEnable = 1;
		pcaWriteSelect = 1;
		tick(5);
		chk("hostWrIntFlag", 1, hostWrIntFlag);
		chk("hostInterrupt", 1, hostInterrupt);
		u_pca.wr(16'hA5C3, 0, 0, ok);
		chk("demand", 1, ok);
		takeHost(16'hA5C3);
		chk("fault", 0, controller_parity_fault);
		u_pca.wr(16'h3C5A, 1, 3, ok);
		chk("fault", 1, controller_parity_fault);
		takeHost(16'h3C5A);
		restart();
		tick(1);
		chk("fault", 0, controller_parity_fault);
		pcaWriteSelect = 0;
	endtask : sc_write
	task automatic sc_read();
		int p;
		readEnable = 1;
		pcaReadSelect = 1;
		tick(5);
		chk("hostRdIntFlag", 1, hostRdIntFlag);
		for (p = 0; p < 2; p++)
		begin
			evenParity = p[0];
			fork
				u_pca.rd(2, p[0], d, ok);
				giveHost(16'h1234 ^ p[15:0]);
			join
			chk("read word", 16'h1234 ^ p[15:0], d);
			chk("adapter parity", p[0], pcaParityError);
			chk("hostParityErr", p[0], hostParityErr);
		end
		pcaReadSelect = 0;
		restart();
	endtask : sc_read
	task automatic sc_done();
		hostEndRecord = 1;
		tick(1);
		hostEndRecord = 0;
		tick(1);
		chk("done line", 1, transfer_done_line);
		chk("end status", 1, endStatus);
		hostMfIntReq = 1;
		tick(2);
		chk("pcaInterrupt", 1, pcaInterrupt);
		hostMfIntReq = 0;
		pcaWriteSelect = 1;
		tick(5);
		u_pca.wr(16'h0F0F, 0, 0, ok);
		chk("refused", 0, ok);
		restart();
		tick(1);
		chk("done line", 0, transfer_done_line);
		pcaWriteSelect = 0;
	endtask : sc_done
	initial
	begin
		{rst_n, writeEnable, readEnable, evenParity, hostStart, hostEndRecord} = 6'h00;
		{hostMfIntReq, brkAckIn, brkAckOut, pcaWriteSelect, pcaReadSelect} = 5'h00;
		brkDataOut = 16'h0000;
		tick(20);
		rst_n = 1;
		restart();
		sc_write();
		sc_read();
		sc_done();
		end_sim();
	end
	// the scenarios need well under a thousand cycles
	initial
	begin
		repeat (5000) @(posedge clk);
		errors++;
		end_sim();
	end
endmodule : tb
